// *** logic/sarpc_consts.svh ***
// constants of the converter serial readout and power-mode control
// Functional notes
// [R1] select falling edge: hold, sample, start conversion, drive serial output.
// [R2] conversion plus full readout takes sixteen serial clocks after select falls.
// [R3] after thirteen falling edges, back to track on the next rising edge.
// [R4] sixteenth falling edge releases the serial output to high impedance.
// [R5] select rising before sixteen clocks aborts conversion and releases output.
// [R6] each result bit is shifted out on a serial clock falling edge.
// [R7] 12-bit frame: four zeros then the result, msb first.
// [R8] 10-bit frame: four zeros, result msb first, then two zeros.
// [R9] result is plain unsigned binary, zero at the pseudo-ground level.
// [R10] select fall gives first zero; each falling edge gives the next bit.
// [R11] last bit driven on edge fifteen, captured by host on edge sixteen.
// [R12] host waits at least 60 ns quiet after release before next select fall.
// [R13] host keeps the track interval before sampling at least 290 ns.
// [R14] host should use eighteen-clock bursts at 18 MHz for full rate.
// [R15] host may capture on rising edges; sixteenth rising carries the lsb.
// [R16] select low for ten falling edges keeps the device fully powered.
// [R17] rise between edges ten and sixteen: stay powered, abort, release output.
// [R18] select may idle high or low, but is high before the next start.
// [R19] rise between edges two and ten: power down, abort, release output.
// [R20] rise before the second falling edge keeps normal mode.
// [R21] in power-down all analog circuitry stays off until a valid wake-up.
// [R22] dummy conversion past edge ten wakes; powered 1 us after select fall.
// [R23] from power-down, rise before edge ten returns to power-down.
// [R24] waking from power-down, track again on first serial clock edge.
// [R25] host runs one dummy cycle after power-on to set the mode.
// [R26] count falling edges per frame, cleared on select rise, for all decisions; wake-up track also takes the first rising edge.
// [R27] select high keeps output released and serial clock ignored.
`ifndef SARPC_CONSTS_SVH
`define SARPC_CONSTS_SVH

// frame shape, in serial clock falling edges
`define SARPC_FRAME_EDGES   5'h10
`define SARPC_LEAD_ZEROS    5'h04
`define SARPC_TRACK_EDGES   5'h0D
`define SARPC_PD_MIN_EDGES  5'h02
`define SARPC_NORM_EDGES    5'h0A
`define SARPC_CNT_W         5

// flag positions handed from the link domain
`define SARPC_F_GE1         0
`define SARPC_F_GE2         1
`define SARPC_F_GE10        2
`define SARPC_F_GE16        3
`define SARPC_F_TRACK       4
`define SARPC_F_RISE        5
`define SARPC_F_W           6

// power-up time and its cycle count at the system clock
`define SARPC_PWRUP_NS      1000
`define SARPC_SYS_CLK_MHZ   40
`define SARPC_PWRUP_CYC     ((`SARPC_PWRUP_NS * `SARPC_SYS_CLK_MHZ + 999) / 1000)
`define SARPC_PWR_W         6

`endif

// *** logic/sarpc_pkg.sv ***
// types of the converter serial readout and power-mode control
`include "sarpc_consts.svh"

package sarpc_pkg;

    // power mode, one-hot
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_WAKING = 3'b010,
        MODE_DOWN   = 3'b100
    } sarpc_mode_t;

    // whole state of the system-clock side
    typedef struct packed {
        sarpc_mode_t                 mode;
        logic                        frame_d;
        logic [`SARPC_F_W-1:0]       seen;
        logic [`SARPC_PWR_W-1:0]     pwr_cnt;
        logic                        hold;
        logic                        sample;
        logic                        abort;
        logic                        done;
    } sarpc_core_t;

endpackage

// *** logic/sarpc_sync.sv ***
// two-flop level synchroniser, one lane per bit
`timescale 1ns/100ps

module sarpc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    // levels in and out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sarpc_sync_t;

    sarpc_sync_t st_r;
    sarpc_sync_t st_nxt;

    generate
        if (W < 1) begin : g_bad_w
            $error("sarpc_sync width must be positive");
        end
    endgenerate

    // first stage feeds only the second
    always_comb begin
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;
endmodule

// *** logic/sarpc_link.sv ***
// serial-clock side: edge count, result shifter and frame flags
`timescale 1ns/100ps

module sarpc_link
    import sarpc_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    // link pins
    input  wire logic                  serial_clk,
    input  wire logic                  select_n,
    output logic                       serial_result_out,
    output logic                       serial_result_oe,
    // code from the successive-approximation array
    input  wire logic [RES_BITS-1:0]   sample_code,
    // frame flags, flop outputs, for the other domain
    output logic [`SARPC_F_W-1:0]      frame_flags
);
    typedef struct packed {
        logic [`SARPC_CNT_W-1:0] cnt;
        logic                    sdo;
        logic [RES_BITS-1:0]     shreg;
        logic                    ge1;
        logic                    ge2;
        logic                    ge10;
        logic                    ge16;
    } sarpc_fall_t;

    typedef struct packed {
        logic track;
        logic rise_any;
    } sarpc_rise_t;

    sarpc_fall_t fall_r;
    sarpc_fall_t fall_nxt;
    sarpc_rise_t rise_r;
    sarpc_rise_t rise_nxt;
    logic [`SARPC_CNT_W-1:0] cnt_inc;

    generate
        if (RES_BITS != 10 && RES_BITS != 12) begin : g_bad_res
            $error("sarpc_link supports 10 or 12 result bits");
        end
    endgenerate

    // falling-edge side: new count k presents frame bit k
    always_comb begin
        fall_nxt = fall_r;
        cnt_inc  = fall_r.cnt + `SARPC_CNT_W'(1);
        if (fall_r.cnt < `SARPC_FRAME_EDGES) begin
            fall_nxt.cnt = cnt_inc;                        // [R26]
        end
        if (cnt_inc == `SARPC_LEAD_ZEROS) begin
            // code is plain binary, loaded msb first     // [R9]
            fall_nxt.sdo   = sample_code[RES_BITS-1];      // [R7] [R8]
            fall_nxt.shreg = {sample_code[RES_BITS-2:0], 1'b0};
        end else if (cnt_inc > `SARPC_LEAD_ZEROS) begin
            // emptied shifter yields the 10-bit tail zeros
            fall_nxt.sdo   = fall_r.shreg[RES_BITS-1];     // [R6] [R8] [R11]
            fall_nxt.shreg = {fall_r.shreg[RES_BITS-2:0], 1'b0};
        end else begin
            fall_nxt.sdo = 1'b0;                           // [R10]
        end
        fall_nxt.ge1  = fall_r.ge1  | (cnt_inc >= 5'h01);
        fall_nxt.ge2  = fall_r.ge2  | (cnt_inc >= `SARPC_PD_MIN_EDGES);
        fall_nxt.ge10 = fall_r.ge10 | (cnt_inc >= `SARPC_NORM_EDGES);
        fall_nxt.ge16 = fall_r.ge16 | (cnt_inc >= `SARPC_FRAME_EDGES);
    end

    // select high clears the frame and keeps it clear while the clock runs
    always_ff @(negedge serial_clk or posedge select_n) begin
        if (select_n) begin
            fall_r <= '0;                                  // [R26] [R27]
        end else begin
            fall_r <= fall_nxt;
        end
    end

    // rising-edge side: return to track after edge thirteen
    always_comb begin
        rise_nxt          = rise_r;
        rise_nxt.rise_any = 1'b1;
        if (fall_r.cnt >= `SARPC_TRACK_EDGES) begin
            rise_nxt.track = 1'b1;                         // [R3]
        end
    end

    always_ff @(posedge serial_clk or posedge select_n) begin
        if (select_n) begin
            rise_r <= '0;
        end else begin
            rise_r <= rise_nxt;
        end
    end

    // driven from select fall until edge sixteen or select rise
    assign serial_result_oe  = !select_n && !fall_r.ge16; // [R1] [R4] [R5]
    assign serial_result_out = fall_r.sdo;

    always_comb begin
        frame_flags                  = '0;
        frame_flags[`SARPC_F_GE1]    = fall_r.ge1;
        frame_flags[`SARPC_F_GE2]    = fall_r.ge2;
        frame_flags[`SARPC_F_GE10]   = fall_r.ge10;
        frame_flags[`SARPC_F_GE16]   = fall_r.ge16;
        frame_flags[`SARPC_F_TRACK]  = rise_r.track;
        frame_flags[`SARPC_F_RISE]   = rise_r.rise_any;
    end
endmodule

// *** logic/sarpc_top.sv ***
// converter control top: power modes, track-and-hold and frame events
`timescale 1ns/100ps

module sarpc_top
    import sarpc_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    // system clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    // link pins from the host
    input  wire logic                 serial_clk,
    input  wire logic                 select_n,
    // serial result pin, output only
    output logic                      serial_result_out,
    output logic                      serial_result_oe,
    // successive-approximation array
    input  wire logic [RES_BITS-1:0]  sample_code,
    // analog control
    output logic                      track_hold_hold,
    output logic                      analog_power_on,
    output logic                      analog_ready,
    output logic                      power_down_mode,
    // frame events
    output logic                      sample_start,
    output logic                      conv_abort,
    output logic                      conv_done
);
    localparam int PWR_CYC = `SARPC_PWRUP_CYC;
    localparam logic [`SARPC_PWR_W-1:0] PWR_LAST =
        `SARPC_PWR_W'(PWR_CYC);

    sarpc_core_t st_r;
    sarpc_core_t st_nxt;

    logic [`SARPC_F_W-1:0] link_flags;
    logic [`SARPC_F_W:0]   sync_q;
    logic [`SARPC_F_W-1:0] flags_s;
    logic [`SARPC_F_W-1:0] flags_now;
    logic                  frame_s;
    logic                  frame_fall;
    logic                  frame_rise;
    logic                  in_down;
    logic                  track_ok;

    generate
        if (RES_BITS != 10 && RES_BITS != 12) begin : g_bad_res
            $error("sarpc_top supports 10 or 12 result bits");
        end
        if (PWR_CYC < 1 || PWR_CYC >= (1 << `SARPC_PWR_W)) begin : g_bad_pw
            $error("power-up count does not fit its counter");
        end
    endgenerate

    // link-domain logic on the host's serial clock
    sarpc_link #(
        .RES_BITS (RES_BITS)
    ) u_link (
        .serial_clk        (serial_clk),
        .select_n          (select_n),
        .serial_result_out (serial_result_out),
        .serial_result_oe  (serial_result_oe),
        .sample_code       (sample_code),
        .frame_flags       (link_flags)
    );

    // select pin and link flags are levels: two flops each
    sarpc_sync #(
        .W (`SARPC_F_W + 1)
    ) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({~select_n, link_flags}),
        .sync_out (sync_q)
    );

    assign frame_s    = sync_q[`SARPC_F_W];
    assign flags_s    = sync_q[`SARPC_F_W-1:0];
    assign frame_fall = frame_s && !st_r.frame_d;
    assign frame_rise = !frame_s && st_r.frame_d;
    // flags clear at once on select rise, so keep what was seen low
    assign flags_now  = st_r.seen | flags_s;
    assign in_down    = (st_r.mode == MODE_DOWN);

    // track is allowed again after edge thirteen, or on any edge
    // of a wake-up frame
    always_comb begin
        track_ok = flags_now[`SARPC_F_TRACK];              // [R3]
        if (st_r.mode == MODE_WAKING &&
            (flags_now[`SARPC_F_RISE] || flags_now[`SARPC_F_GE1])) begin
            track_ok = 1'b1;                               // [R24]
        end
    end

    // mode machine and frame bookkeeping
    always_comb begin
        st_nxt         = st_r;
        st_nxt.frame_d = frame_s;
        st_nxt.sample  = 1'b0;
        st_nxt.abort   = 1'b0;
        st_nxt.done    = 1'b0;

        if (frame_fall) begin
            st_nxt.seen   = '0;                            // [R26]
            st_nxt.sample = 1'b1;                          // [R1]
        end else if (frame_s) begin
            st_nxt.seen = flags_now;
            // sixteen edges complete the frame            // [R2]
            if (flags_s[`SARPC_F_GE16] && !st_r.seen[`SARPC_F_GE16]) begin
                st_nxt.done = 1'b1;                        // [R4]
            end
        end

        unique case (st_r.mode)
            MODE_NORMAL: begin
                if (frame_rise) begin
                    if (!flags_now[`SARPC_F_GE16]) begin
                        st_nxt.abort = 1'b1;               // [R5] [R17]
                    end
                    // glitch guard below edge two, stay up   [R20]
                    if (flags_now[`SARPC_F_GE2] &&
                        !flags_now[`SARPC_F_GE10]) begin
                        st_nxt.mode = MODE_DOWN;           // [R19]
                    end
                    // ten edges or more keep it powered       [R16]
                end
            end
            MODE_DOWN: begin
                if (frame_fall) begin
                    st_nxt.mode = MODE_WAKING;             // [R22]
                end
            end
            MODE_WAKING: begin
                if (frame_rise) begin
                    if (!flags_now[`SARPC_F_GE16]) begin
                        st_nxt.abort = 1'b1;               // [R5]
                    end
                    if (flags_now[`SARPC_F_GE10]) begin
                        st_nxt.mode = MODE_NORMAL;         // [R22]
                    end else begin
                        st_nxt.mode = MODE_DOWN;           // [R23]
                    end
                end
            end
        endcase

        // power-up timer runs from the wake-up select fall
        if (st_nxt.mode == MODE_DOWN) begin
            st_nxt.pwr_cnt = '0;                           // [R21]
        end else if (st_r.pwr_cnt != PWR_LAST) begin
            st_nxt.pwr_cnt = st_r.pwr_cnt + `SARPC_PWR_W'(1); // [R22]
        end

        // hold from select fall until track is allowed; held while down
        if (st_nxt.mode == MODE_DOWN) begin
            st_nxt.hold = 1'b1;
        end else if (frame_fall) begin
            st_nxt.hold = 1'b1;                            // [R1]
        end else if (frame_s) begin
            st_nxt.hold = st_r.hold && !track_ok;
        end else begin
            st_nxt.hold = 1'b0;
        end
    end

    // every register on every edge; reset lands in normal mode
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_r      <= '0;
            st_r.mode <= MODE_NORMAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    assign track_hold_hold = st_r.hold;
    assign analog_power_on = !in_down;                     // [R21]
    assign power_down_mode = in_down;
    assign analog_ready    = (st_r.mode == MODE_NORMAL) &&
                             (st_r.pwr_cnt == PWR_LAST);
    assign sample_start    = st_r.sample;
    assign conv_abort      = st_r.abort;
    assign conv_done       = st_r.done;
endmodule

// *** testbench/sarpc_properties.sv ***
// assertions on the converter control top ports
`timescale 1ns/100ps

module sarpc_properties #(
    parameter int RES_BITS = 12
) (
    // system clock and reset
    input wire logic                sys_clk,
    input wire logic                reset_n,
    // link pins
    input wire logic                serial_clk,
    input wire logic                select_n,
    input wire logic                serial_result_out,
    input wire logic                serial_result_oe,
    input wire logic [RES_BITS-1:0] sample_code,
    // analog control and events
    input wire logic                track_hold_hold,
    input wire logic                analog_power_on,
    input wire logic                analog_ready,
    input wire logic                power_down_mode,
    input wire logic                sample_start,
    input wire logic                conv_abort,
    input wire logic                conv_done
);
    logic [5:0] up_cnt_r;

    // cycles with analog power on, saturating so it never wraps
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !analog_power_on)
            up_cnt_r <= 6'h00;
        else if (up_cnt_r != 6'h3F)
            up_cnt_r <= up_cnt_r + 6'h01;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_idle_quiet: assert property (
        select_n |-> !serial_result_oe && !serial_result_out)
        else $error("output active while deselected");
    chk_start_hold: assert property (
        $fell(select_n) |-> ##[1:4] (sample_start && track_hold_hold))
        else $error("no hold after select fall");
    chk_done_late: assert property (
        $fell(serial_result_oe) && !select_n |-> ##[1:5] conv_done)
        else $error("no done after last edge");
    chk_done_off: assert property (
        conv_done |-> !serial_result_oe && !$past(conv_done))
        else $error("done while still driving");
    chk_abort_rise: assert property (
        $rose(select_n) && $past(serial_result_oe) |-> ##[1:5] conv_abort)
        else $error("no abort after early rise");
    chk_abort_cause: assert property (
        conv_abort |-> $past(select_n, 2))
        else $error("abort without select rise");
    chk_pd_dark: assert property (
        power_down_mode |-> !analog_power_on && !analog_ready)
        else $error("analog alive in power-down");
    chk_ready_time: assert property (
        $rose(analog_ready) |-> up_cnt_r >= 6'h26)
        else $error("ready before power-up time");
    chk_ready_mode: assert property (
        analog_ready |-> analog_power_on && !power_down_mode)
        else $error("ready outside normal mode");

    cov_done: cover property (conv_done);
    cov_abort: cover property (conv_abort);
    cov_down: cover property ($rose(power_down_mode));
    cov_ready: cover property ($rose(analog_ready));
endmodule

bind sarpc_top sarpc_properties #(.RES_BITS(RES_BITS)) u_props (
    .sys_clk(sys_clk), .reset_n(reset_n), .serial_clk(serial_clk),
    .select_n(select_n), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .sample_code(sample_code),
    .track_hold_hold(track_hold_hold), .analog_power_on(analog_power_on),
    .analog_ready(analog_ready), .power_down_mode(power_down_mode),
    .sample_start(sample_start), .conv_abort(conv_abort),
    .conv_done(conv_done));

// *** testbench/sarpc_host_model.sv ***
// host serial port model: select, serial clock and result capture
`timescale 1ns/100ps

module sarpc_host_model #(
    parameter int LANES = 2
) (
    // link pins driven by the host
    output logic                   serial_clk,
    output logic                   select_n,
    // result lanes from the converters
    input  wire logic [LANES-1:0]  sdo,
    input  wire logic [LANES-1:0]  sdo_oe
);
    logic [15:0] word [LANES];
    logic [15:0] word_up [LANES];
    int          idx;

    // clock starts low and runs only while clocks is called, select idles high
    initial begin
        serial_clk = 1'b0;
        select_n = 1'b1;
    end

    // open a frame; capture index restarts
    task automatic start();
        idx = 0;
        for (int l = 0; l < LANES; l++) begin
            word[l] = 'x;
            word_up[l] = 'x;
        end
        #10 select_n = 1'b0;
    endtask

    // n clock cycles; a released lane is captured as unknown
    task automatic clocks(input int n);
        for (int i = 0; i < n; i++) begin
            #7.5 serial_clk = 1'b1;
            // slow-clock option: bit k is read at rising edge k+1
            if (!select_n && idx < 16)
                for (int l = 0; l < LANES; l++)
                    word_up[l][15-idx] = sdo_oe[l] ? sdo[l] : 1'bx;
            #7.5;
            if (!select_n && idx < 16) begin
                for (int l = 0; l < LANES; l++)
                    word[l][15-idx] = sdo_oe[l] ? sdo[l] : 1'bx;
                idx++;
            end
            serial_clk = 1'b0;
        end
    endtask

    // late rise keeps the last edge counted; then quiet and track time
    task automatic stop();
        #60 select_n = 1'b1;
        #300;
    endtask
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for serial readout and power modes
`timescale 1ns/100ps

module tb_top;
    logic        sys_clk;
    logic        reset_n;
    logic [11:0] code12;
    logic [9:0]  code10;
    wire         serial_clk;
    wire         select_n;
    logic [1:0]  sdo;
    logic [1:0]  sdo_oe;
    logic [1:0]  hold;
    logic [1:0]  pwr_on;
    logic [1:0]  ready;
    logic [1:0]  pd;
    logic [1:0]  starts;
    logic [1:0]  aborts;
    logic [1:0]  dones;
    logic [14:0] ev_cnt;
    logic [14:0] ev_base;
    int          miscompares;
    int          compares;

    // 12-bit and 10-bit variants share the host link
    sarpc_top #(.RES_BITS(12)) uut (
        .sys_clk(sys_clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .select_n(select_n), .serial_result_out(sdo[0]),
        .serial_result_oe(sdo_oe[0]), .sample_code(code12),
        .track_hold_hold(hold[0]), .analog_power_on(pwr_on[0]),
        .analog_ready(ready[0]), .power_down_mode(pd[0]),
        .sample_start(starts[0]), .conv_abort(aborts[0]),
        .conv_done(dones[0]));
    sarpc_top #(.RES_BITS(10)) uut_10b (
        .sys_clk(sys_clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .select_n(select_n), .serial_result_out(sdo[1]),
        .serial_result_oe(sdo_oe[1]), .sample_code(code10),
        .track_hold_hold(hold[1]), .analog_power_on(pwr_on[1]),
        .analog_ready(ready[1]), .power_down_mode(pd[1]),
        .sample_start(starts[1]), .conv_abort(aborts[1]),
        .conv_done(dones[1]));
    sarpc_host_model #(.LANES(2)) host (
        .serial_clk(serial_clk), .select_n(select_n),
        .sdo(sdo), .sdo_oe(sdo_oe));

    // 40 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // event pulses of both variants in start, abort and done fields;
    // fields stay far below 32, so no carry crosses between them
    always @(posedge sys_clk) begin
        if (!reset_n)
            ev_cnt <= 15'h0000;
        else
            ev_cnt <= ev_cnt + {5'(starts[0]) + 5'(starts[1]),
                                5'(aborts[0]) + 5'(aborts[1]),
                                5'(dones[0]) + 5'(dones[1])};
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // lets the synchronised flags and mode decisions land
    task automatic settle();
        repeat (8) @(negedge sys_clk);
    endtask

    // full frames at full-scale, near-zero and mixed codes, 18-edge bursts
    task automatic t_frame();
        logic [11:0] codes [3] = '{12'hFFF, 12'h001, 12'hA5C};
        for (int i = 0; i < 3; i++) begin
            @(negedge sys_clk);
            code12 = codes[i];
            code10 = codes[i][11:2];
            host.start();
            host.clocks(12);
            settle();
            check(hold, 2'b11);
            host.clocks(2);
            settle();
            check(hold, 2'b00);
            host.clocks(4);
            check(sdo_oe, 2'b00);
            check(host.word[0], {4'h0, codes[i]});
            check(host.word[1], {4'h0, codes[i][11:2], 2'b00});
            check(host.word_up[0], {4'h0, codes[i]});
            host.stop();
            check(pd, 2'b00);
            check(16'(ev_cnt - ev_base), 16'h0802);
            ev_base = ev_cnt;
        end
        $display("t_frame done");
    endtask

    // rise right after edge ten: abort, stay powered
    task automatic t_abort();
        host.start();
        host.clocks(10);
        check(sdo_oe, 2'b11);
        host.stop();
        check({sdo_oe, pd}, 4'h0);
        check(16'(ev_cnt - ev_base), 16'h0840);
        ev_base = ev_cnt;
        $display("t_abort done");
    endtask

    // idle clocks ignored, enter power-down, stay, then wake
    task automatic t_power();
        int n;
        host.clocks(20);
        check(sdo_oe, 2'b00);
        host.start();
        host.clocks(2);
        host.stop();
        check({pd, pwr_on}, 4'hC);
        check(16'(ev_cnt - ev_base), 16'h0840);
        ev_base = ev_cnt;
        host.start();
        host.clocks(9);
        host.stop();
        check({pd, pwr_on}, 4'hC);
        check(16'(ev_cnt - ev_base), 16'h0840);
        ev_base = ev_cnt;
        host.start();
        host.clocks(1);
        settle();
        check(hold, 2'b00);
        host.clocks(9);
        host.stop();
        check(pd, 2'b00);
        check(16'(ev_cnt - ev_base), 16'h0840);
        ev_base = ev_cnt;
        for (n = 0; n < 80 && ready !== 2'b11; n++)
            @(negedge sys_clk);
        check(ready, 2'b11);
        if (ready !== 2'b11)
            print_verdict();
        $display("t_power done");
    endtask

    // select glitch before edge two keeps normal mode
    task automatic t_glitch();
        host.start();
        host.clocks(1);
        host.stop();
        check({pd, ready}, 4'h3);
        check(16'(ev_cnt - ev_base), 16'h0840);
        ev_base = ev_cnt;
        $display("t_glitch done");
    endtask

    // reset, one dummy cycle, then the scenarios
    initial begin
        reset_n = 1'b0;
        code12 = 12'h000;
        code10 = 10'h000;
        miscompares = 0;
        compares = 0;
        ev_base = 15'h0000;
        repeat (6) @(negedge sys_clk);
        check({pd, ready, pwr_on}, 6'h03);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        host.start();
        host.clocks(16);
        host.stop();
        check(16'(ev_cnt - ev_base), 16'h0802);
        ev_base = ev_cnt;
        t_frame();
        t_abort();
        t_power();
        t_glitch();
        print_verdict();
    end
endmodule
